// ### core/tcu_defs.svh
// constants for the general-purpose timer/counter
`ifndef TCU_DEFS_SVH
`define TCU_DEFS_SVH

`define TCU_CNT_W       8
`define TCU_DIV_W       11
`define TCU_PRESC_W     4
`define TCU_PRESC_MAX   4'h8
`define TCU_PRESC_EXT   4'h9
`define TCU_DIV_BASE    11'h007
`define TCU_FILT_CYC    3
`define TCU_FILT_W      2
`define TCU_CH_N        2

`endif

// ### core/tcu_pkg.sv
// types shared by the timer/counter
`include "tcu_defs.svh"
package tcu_pkg;

  typedef enum logic [2:0] {
    TCU_FREE_RUN,
    TCU_CLEAR_ON_A,
    TCU_PWM,
    TCU_PPG,
    TCU_EVENT,
    TCU_ONE_SHOT
  } tcu_mode_t;

  typedef struct packed {
    tcu_mode_t                 mode;
    logic [`TCU_PRESC_W-1:0]   presc_sel;
    logic [`TCU_CH_N-1:0]      output_enable_bit;
    logic [`TCU_CH_N-1:0]      active_level_bit;
  } tcu_cfg_t;

  typedef struct packed {
    logic                      overflow_flag;
    logic                      match_a_flag;
    logic                      match_b_flag;
    logic                      capture_flag;
  } tcu_flags_t;

endpackage : tcu_pkg

// ### core/tcu_timer.sv
// up-counter with two compares, one capture, pwm/ppg, event and one-shot modes
//
// How it works
// - clearing the run bit in pwm or ppg mode puts the output at its active level.
// - an output whose enable bit is 0 shows the inverse of its active-level bit.
// - free-running mode counts through matches and flags every match.
// - the prescaler picks fosc over 8 up to 2048 in powers of two, or the external clock.
// - clear-on-match mode restarts the count at compare a, flagging once per period.
// - a pin edge counts only after both levels held for 3 system clocks.
// - every valid capture pin edge, rising or falling, copies the count into capture_reg.
// - free-running mode never clears the counter on capture or compare.
// - pwm mode sets the duty to compare/256 with the period one full count.
// - ppg mode takes its period from compare b and its pulse width from compare a.
// - event mode counts filtered rising edges of the count input pin.
// - in event mode the count equals received pulses minus one.
// - one-shot mode flags one compare a match and then stops at overflow.
// - clearing the overflow flag starts the next one-shot cycle.
`timescale 1ns/1ps
`default_nettype none
`include "tcu_defs.svh"

module tcu_timer
  import tcu_pkg::*;
#(
  parameter int CNT_W = `TCU_CNT_W
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rstn_in,
  // control
  input  wire logic              counter_run_bit_in,
  input  wire tcu_cfg_t          cfg_in,
  input  wire logic [CNT_W-1:0]  compare_reg_a_in,
  input  wire logic [CNT_W-1:0]  compare_reg_b_in,
  input  wire tcu_flags_t        flag_clear_in,
  // pins
  input  wire logic              capture_trigger_pin_in,
  input  wire logic              count_input_pin_in,
  output logic [`TCU_CH_N-1:0]   timer_output_pin_out,
  // status
  output logic [CNT_W-1:0]       main_counter_out,
  output logic [CNT_W-1:0]       capture_reg_out,
  output tcu_flags_t             flags_out
);

  // tick when the low divider bits of the chosen ratio are all ones
  function automatic logic presc_tick(input logic [`TCU_DIV_W-1:0]   div,
                                      input logic [`TCU_PRESC_W-1:0] sel);
    logic [`TCU_DIV_W-1:0] mask;
    mask = `TCU_DIV_BASE;
    for (int i = 0; i < int'(`TCU_PRESC_MAX); i++) begin
      if (sel > i[`TCU_PRESC_W-1:0]) begin
        mask = {mask[`TCU_DIV_W-2:0], 1'b1};
      end
    end
    presc_tick = ((div & mask) == mask);
  endfunction : presc_tick

  // prescaler divider, free running
  logic [`TCU_DIV_W-1:0] div_r;
  logic [`TCU_DIV_W-1:0] div_nxt;

  always_comb begin
    div_nxt = div_r + `TCU_DIV_W'(1);
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // pin synchronisers and glitch filters, index 0 capture, 1 count input
  logic [1:0] pin_raw;
  logic [1:0] rise;
  logic [1:0] fall;
  assign pin_raw = {count_input_pin_in, capture_trigger_pin_in};

  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic                  s1_r;
    logic                  s2_r;
    logic                  lvl_r;
    logic                  lvl_nxt;
    logic [`TCU_FILT_W-1:0] cnt_r;
    logic [`TCU_FILT_W-1:0] cnt_nxt;

    // a level must hold for the full count before it is believed
    always_comb begin
      lvl_nxt = lvl_r;
      cnt_nxt = '0;
      if (s2_r != lvl_r) begin
        if (cnt_r == `TCU_FILT_W'(`TCU_FILT_CYC - 1)) begin
          lvl_nxt = s2_r;
        end else begin
          cnt_nxt = cnt_r + `TCU_FILT_W'(1);
        end
      end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        s1_r  <= 1'b0;
        s2_r  <= 1'b0;
        lvl_r <= 1'b0;
        cnt_r <= '0;
      end else begin
        s1_r  <= pin_raw[g];
        s2_r  <= s1_r;
        lvl_r <= lvl_nxt;
        cnt_r <= cnt_nxt;
      end
    end

    assign rise[g] = lvl_nxt & ~lvl_r;
    assign fall[g] = ~lvl_nxt & lvl_r;
  end

  // count clock selection
  logic tick;
  always_comb begin
    if (cfg_in.mode == TCU_EVENT || cfg_in.presc_sel == `TCU_PRESC_EXT) begin
      tick = rise[1];
    end else if (cfg_in.presc_sel > `TCU_PRESC_MAX) begin
      tick = 1'b0;                                           // undefined ratio holds the count
    end else begin
      tick = presc_tick(div_r, cfg_in.presc_sel);
    end
  end

  // counter, flags, capture and output levels
  logic [CNT_W-1:0]     cnt_r;
  logic [CNT_W-1:0]     cnt_nxt;
  logic [CNT_W-1:0]     cap_r;
  logic [CNT_W-1:0]     cap_nxt;
  tcu_flags_t           flg_r;
  tcu_flags_t           flg_nxt;
  logic                 started_r;
  logic                 started_nxt;
  logic [`TCU_CH_N-1:0] lvl_r;
  logic [`TCU_CH_N-1:0] lvl_nxt;
  logic [`TCU_CH_N-1:0] pin_r;
  logic [`TCU_CH_N-1:0] pin_nxt;
  logic [CNT_W-1:0]     inc;
  logic [`TCU_CH_N-1:0] hit;
  logic                 wrap;
  logic                 pulse_mode;

  always_comb begin
    inc        = cnt_r + CNT_W'(1);
    wrap       = (cnt_r == '1);
    hit        = {inc == compare_reg_b_in, inc == compare_reg_a_in};
    pulse_mode = (cfg_in.mode == TCU_PWM) || (cfg_in.mode == TCU_PPG);
    cnt_nxt     = cnt_r;
    cap_nxt     = cap_r;
    started_nxt = started_r;
    lvl_nxt     = lvl_r;
    // software clears first so that a same-cycle event still sets
    flg_nxt     = flg_r & ~flag_clear_in;

    if (rise[0] || fall[0]) begin
      cap_nxt               = cnt_r;
      flg_nxt.capture_flag  = 1'b1;
    end

    if (!counter_run_bit_in) begin
      started_nxt = 1'b0;
      if (pulse_mode) begin
        lvl_nxt = '1;
      end
    end else if (tick && !started_r) begin
      // first count clock after start only arms, so events read pulses minus one
      started_nxt = 1'b1;
    end else if (tick) begin
      unique case (cfg_in.mode)
        TCU_PPG: begin
          if (cnt_r == compare_reg_b_in) begin
            cnt_nxt              = '0;
            flg_nxt.match_b_flag = 1'b1;
            lvl_nxt[0]           = 1'b1;
          end else begin
            cnt_nxt = inc;
            if (hit[0]) begin
              flg_nxt.match_a_flag = 1'b1;
              lvl_nxt[0]           = 1'b0;
            end
          end
        end
        TCU_CLEAR_ON_A: begin
          cnt_nxt = hit[0] ? '0 : inc;
          if (wrap && !hit[0]) begin
            flg_nxt.overflow_flag = 1'b1;
          end
          if (hit[0]) begin
            flg_nxt.match_a_flag = 1'b1;
            lvl_nxt[0]           = ~lvl_r[0];
          end
          if (hit[1]) begin
            flg_nxt.match_b_flag = 1'b1;
            lvl_nxt[1]           = ~lvl_r[1];
          end
        end
        TCU_ONE_SHOT: begin
          // parked at zero while the overflow flag stands
          if (!flg_r.overflow_flag) begin
            cnt_nxt = inc;
            if (wrap) begin
              flg_nxt.overflow_flag = 1'b1;
            end
            if (hit[0]) begin
              flg_nxt.match_a_flag = 1'b1;
            end
          end
        end
        TCU_PWM: begin
          cnt_nxt = inc;
          if (wrap) begin
            flg_nxt.overflow_flag = 1'b1;
            lvl_nxt               = '1;
          end
          if (hit[0]) begin
            flg_nxt.match_a_flag = 1'b1;
            lvl_nxt[0]           = 1'b0;
          end
          if (hit[1]) begin
            flg_nxt.match_b_flag = 1'b1;
            lvl_nxt[1]           = 1'b0;
          end
        end
        TCU_FREE_RUN, TCU_EVENT: begin
          cnt_nxt = inc;
          if (wrap) begin
            flg_nxt.overflow_flag = 1'b1;
          end
          for (int c = 0; c < `TCU_CH_N; c++) begin
            if (hit[c]) begin
              lvl_nxt[c] = ~lvl_r[c];
            end
          end
          if (hit[0]) begin
            flg_nxt.match_a_flag = 1'b1;
          end
          if (hit[1]) begin
            flg_nxt.match_b_flag = 1'b1;
          end
        end
        default: begin
          cnt_nxt = cnt_r;                                   // illegal mode code holds
        end
      endcase
    end

    // ppg drives only the first output; while running the second rests inactive
    if (cfg_in.mode == TCU_PPG && counter_run_bit_in) begin
      lvl_nxt[1] = 1'b0;
    end

    for (int c = 0; c < `TCU_CH_N; c++) begin
      if (cfg_in.output_enable_bit[c]) begin
        pin_nxt[c] = lvl_nxt[c] ? cfg_in.active_level_bit[c] : ~cfg_in.active_level_bit[c];
      end else begin
        pin_nxt[c] = ~cfg_in.active_level_bit[c];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r     <= '0;
      cap_r     <= '0;
      flg_r     <= '0;
      started_r <= 1'b0;
      lvl_r     <= '0;
      pin_r     <= '0;
    end else begin
      cnt_r     <= cnt_nxt;
      cap_r     <= cap_nxt;
      flg_r     <= flg_nxt;
      started_r <= started_nxt;
      lvl_r     <= lvl_nxt;
      pin_r     <= pin_nxt;
    end
  end

  // outputs straight from flops
  assign timer_output_pin_out = pin_r;
  assign main_counter_out     = cnt_r;
  assign capture_reg_out      = cap_r;
  assign flags_out            = flg_r;

endmodule : tcu_timer
`default_nettype wire

// ### bench/tcu_timer_assertions.sv
// port checker for the timer/counter
`timescale 1ns/1ps
`default_nettype none
module tcu_timer_chk
  import tcu_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock, reset, control and pins
  input wire logic             ref_clk_in,
  input wire logic             rstn_in,
  input wire logic             counter_run_bit_in,
  input wire tcu_cfg_t         cfg_in,
  input wire logic [CNT_W-1:0] compare_reg_a_in,
  input wire logic [CNT_W-1:0] compare_reg_b_in,
  input wire tcu_flags_t       flag_clear_in,
  input wire logic             capture_trigger_pin_in,
  input wire logic             count_input_pin_in,
  // observed outputs
  input wire logic [1:0]       timer_output_pin_out,
  input wire logic [CNT_W-1:0] main_counter_out,
  input wire logic [CNT_W-1:0] capture_reg_out,
  input wire tcu_flags_t       flags_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // mode shorthands, config only changes while stopped
  wire logic fr = cfg_in.mode == TCU_FREE_RUN;
  wire logic pp = cfg_in.mode inside {TCU_PWM, TCU_PPG};
  a_pin_disabled:
    assert property (!cfg_in.output_enable_bit[0] |=> timer_output_pin_out[0]
      == !$past(cfg_in.active_level_bit[0])) else $error("idle pin level");
  a_stop_active:
    assert property ((pp && cfg_in.output_enable_bit[0] && !counter_run_bit_in)[*3]
      |-> timer_output_pin_out[0] == cfg_in.active_level_bit[0]) else $error("stop level");
  a_tick_spacing:
    assert property (fr && cfg_in.presc_sel == 4'h0 && $changed(main_counter_out)
      |=> $stable(main_counter_out)[*7]) else $error("tick spacing");
  a_count_step:
    assert property (fr && $changed(main_counter_out) |-> main_counter_out
      == CNT_W'($past(main_counter_out) + 1)) else $error("count step");
  a_wrap_flag:
    assert property (fr && $past(main_counter_out) == '1 && main_counter_out == '0
      |-> flags_out.overflow_flag) else $error("wrap flag");
  a_match_flag:
    assert property (fr && $changed(main_counter_out) && main_counter_out == compare_reg_a_in
      |-> flags_out.match_a_flag) else $error("match flag");
  a_oneshot_park:
    assert property (cfg_in.mode == TCU_ONE_SHOT && flags_out.overflow_flag
      |-> main_counter_out == '0) else $error("one-shot park");
  a_capture_hold:
    assert property ($changed(capture_reg_out) |-> flags_out.capture_flag)
      else $error("capture hold");
  // main scenarios reached
  c_wrap: cover property (flags_out.overflow_flag);
  c_cap: cover property ($rose(flags_out.capture_flag));
  c_stop: cover property (pp && !counter_run_bit_in);
endmodule : tcu_timer_chk
bind tcu_timer tcu_timer_chk #(.CNT_W(CNT_W)) i_chk (.ref_clk_in, .rstn_in,
  .counter_run_bit_in, .cfg_in, .compare_reg_a_in, .compare_reg_b_in, .flag_clear_in,
  .capture_trigger_pin_in, .count_input_pin_in, .timer_output_pin_out,
  .main_counter_out, .capture_reg_out, .flags_out);
`default_nettype wire

// ### bench/tcu_timer_tb.sv
// self-checking bench for the timer/counter
`timescale 1ns/1ps
`default_nettype none
module tcu_timer_tb
  import tcu_pkg::*;
;
  typedef struct packed {
    tcu_mode_t  m;
    logic       r;
    logic [1:0] oe, alv, pin;
  } tcu_row_t;
  logic       clk = 1'h0, rstn = 1'h0, run = 1'h0, cap = 1'h0, cin = 1'h0;
  tcu_cfg_t   cfg = '0;
  logic [7:0] ca = 8'h00, cb = 8'h00, cnt, capv;
  tcu_flags_t fclr = '0, fl;
  logic [1:0] pin;
  int         fails = 0, num_checks = 0, cyc = 0, g, h;
  // mode, run, enable, level, expected pins
  tcu_row_t   rows[5] = '{'{TCU_FREE_RUN, 1'h0, 2'h0, 2'h1, 2'h2},
    '{TCU_FREE_RUN, 1'h1, 2'h0, 2'h2, 2'h1}, '{TCU_PWM, 1'h0, 2'h3, 2'h1, 2'h1},
    '{TCU_PPG, 1'h0, 2'h1, 2'h3, 2'h1}, '{TCU_PPG, 1'h0, 2'h1, 2'h0, 2'h2}};
  tcu_timer i_dut (.ref_clk_in(clk), .rstn_in(rstn), .counter_run_bit_in(run),
    .cfg_in(cfg), .compare_reg_a_in(ca), .compare_reg_b_in(cb), .flag_clear_in(fclr),
    .capture_trigger_pin_in(cap), .count_input_pin_in(cin), .timer_output_pin_out(pin),
    .main_counter_out(cnt), .capture_reg_out(capv), .flags_out(fl));
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // hang guard, whole run needs about 32k cycles
  always @(negedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] v);
    num_checks++;
    if (v !== e) begin
      fails++;
      $display("unexpected %s exp %0h got %0h", nm, e, v);
    end
  endtask : chk
  task automatic wt(int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // fresh reset, then start with both outputs enabled and active high
  task automatic go(tcu_mode_t m, logic [3:0] p, logic [7:0] a, logic [7:0] b);
    rstn = 1'h0;
    run = 1'h0;
    cfg = '{m, p, 2'h3, 2'h3};
    ca = a;
    cb = b;
    wt(2);
    rstn = 1'h1;
    wt(2);
    run = 1'h1;
  endtask : go
  task automatic wf(int i);
    for (int k = 0; k < 5000 && fl[i] !== 1'h1; k++) @(negedge clk);
  endtask : wf
  task automatic clr(logic [3:0] f);
    fclr = f;
    wt(1);
    fclr = '0;
  endtask : clr
  // cycles between two counter steps, the first step is skipped as it may be partial
  task automatic per(output int n);
    logic [7:0] v;
    v = cnt;
    while (cnt === v) @(negedge clk);
    v = cnt;
    n = 0;
    while (cnt === v) begin
      @(negedge clk);
      n++;
    end
  endtask : per
  task automatic hic(int ch, int n, output int k);
    k = 0;
    repeat (n) begin
      @(negedge clk);
      k += int'(pin[ch] === 1'h1);
    end
  endtask : hic
  initial begin
    wt(12);
    chk("reset count", 16'h0000, cnt);
    foreach (rows[i]) begin
      rstn = 1'h0;
      cfg = '{rows[i].m, 4'h0, rows[i].oe, rows[i].alv};
      run = rows[i].r;
      wt(1);
      rstn = 1'h1;
      wt(4);
      chk("pin level", rows[i].pin, pin);
    end
    for (int s = 0; s < 9; s++) begin
      go(TCU_FREE_RUN, 4'(s), 8'h03, 8'h05);
      per(g);
      chk("tick gap", 16'(8 << s), 16'(g));
    end
    go(TCU_FREE_RUN, 4'h0, 8'h03, 8'h05);
    wf(2);
    chk("match a", 16'h0003, cnt);
    wf(1);
    chk("match b", 16'h0005, cnt);
    // software steps compare a forward, the counter keeps running
    clr(4'h4);
    ca = 8'h13;
    wf(2);
    chk("interval", 16'h0013, cnt);
    wf(3);
    chk("wrap", 16'h0000, cnt);
    go(TCU_CLEAR_ON_A, 4'h0, 8'h05, 8'h00);
    wt(60);
    h = 0;
    repeat (200) begin
      @(negedge clk);
      if (cnt > h) h = cnt;
    end
    chk("clear top", 16'h0004, 16'(h));
    // the match must come back within one period once cleared
    clr(4'h4);
    wt(50);
    chk("repeat", 16'h0001, fl.match_a_flag);
    // five full pulses and one glitch on the count pin
    go(TCU_EVENT, 4'h9, 8'hFF, 8'hFF);
    repeat (5) begin
      cin = 1'h1;
      wt(6);
      cin = 1'h0;
      wt(6);
    end
    cin = 1'h1;
    wt(2);
    cin = 1'h0;
    wt(8);
    chk("events", 16'h0004, cnt);
    // external clock selected in free-run: the divider must not clock the counter
    go(TCU_FREE_RUN, 4'h9, 8'hFF, 8'hFF);
    wt(300);
    repeat (2) begin
      cin = 1'h1;
      wt(6);
      cin = 1'h0;
      wt(6);
    end
    chk("ext clock", 16'h0001, cnt);
    // an undefined ratio holds the count
    go(TCU_FREE_RUN, 4'hA, 8'hFF, 8'hFF);
    wt(300);
    chk("no clock", 16'h0000, cnt);
    // slow count so the captured value is known: 1 after about 5000 cycles
    go(TCU_FREE_RUN, 4'h8, 8'h00, 8'h00);
    wt(5000);
    cap = 1'h1;
    wt(2);
    cap = 1'h0;
    wt(10);
    chk("glitch", 16'h0000, fl.capture_flag);
    cap = 1'h1;
    wf(0);
    chk("rise cap", 16'h0001, capv);
    clr(4'h1);
    cap = 1'h0;
    wf(0);
    chk("fall cap", 16'h0001, fl.capture_flag);
    chk("no clear", 16'h0001, cnt);
    go(TCU_PWM, 4'h0, 8'h40, 8'hC0);
    wt(2100);
    hic(0, 2048, h);
    chk("duty a", 16'h0200, 16'(h));
    hic(1, 2048, h);
    chk("duty b", 16'h0600, 16'(h));
    run = 1'h0;
    wt(3);
    chk("pwm stop", 16'h0003, pin);
    go(TCU_PPG, 4'h0, 8'h03, 8'h09);
    wt(200);
    hic(0, 80, h);
    chk("ppg high", 16'h0018, 16'(h));
    go(TCU_ONE_SHOT, 4'h0, 8'h03, 8'h00);
    wf(3);
    clr(4'h4);
    wt(3000);
    chk("one shot", 16'h0000, {cnt, 7'h00, fl.match_a_flag});
    clr(4'h8);
    wf(2);
    chk("restart", 16'h0001, fl.match_a_flag);
    // reset in mid-run clears count, capture, flags and pins at once
    rstn = 1'h0;
    wt(1);
    chk("reset state", 16'h0000, {cnt, capv});
    chk("reset flags", 16'h0000, {fl, pin});
    wrap_up();
  end
endmodule : tcu_timer_tb
`default_nettype wire
